// [pkg/psb_pkg.sv]
// package: constants and carrier types for the pipelined burst sram model
package psb_pkg;

  localparam int ADDR_W    = 17;
  localparam int LANES     = 4;
  localparam int LANE_W    = 9;
  localparam int DATA_W    = LANES * LANE_W;
  localparam int BURST_W   = 2;
  localparam int FIFO_DEPTH = 16;

  // sleep entry / exit takes two qualified-free clock cycles
  localparam logic [1:0] SLEEP_CYCLES = 2'h2;

  localparam logic MODE_LINEAR = 1'b0;

  typedef enum logic [1:0] {
    PSB_IDLE  = 2'b00,
    PSB_READ  = 2'b01,
    PSB_WRITE = 2'b11
  } psb_op_t;

  // one sampled bus command
  typedef struct packed {
    logic               selected;
    logic               adv;
    logic               wr_n;
    logic [LANES-1:0]   lane_n;
    logic [ADDR_W-1:0]  addr;
  } psb_cmd_t;

  // one pending core write
  typedef struct packed {
    logic [ADDR_W-1:0]  addr;
    logic [LANES-1:0]   lane;
    logic [DATA_W-1:0]  data;
  } psb_wr_t;

endpackage : psb_pkg

// [design/psb_sram.sv]
// design: pipelined synchronous burst sram core with write fifo and bus control
// What this block does
// - clock-qualify high freezes every state but the sleep logic and the write fifo
// - clock-qualify high never deselects; it only stretches the current cycle
// - sleep request high enters sleep; contents kept, no new accesses
// - data lines captured into data register on rising edge
// - data and parity driven only while output enable is low
// - float during write data phase, first clock after deselect, and deselected
// - parity lanes behave as data, written per own byte-lane select
// - strap low gives linear burst, high or open gives interleaved
// - selected, qualified, load low: latch presented address as new access
// - write strobe low starts write, high starts read
// - only bytes with asserted lane selects are updated
// - reads, writes, deselects share one pipeline; deselect lands at the same stage as a read
// - every synchronous input but clock qualify registered on rising edge before use; clock qualify gates directly
// - read data leaves through edge-updated output registers
// - writes complete by internal timing; host gives no write pulse
// - load/advance high with qualified clock steps two-bit burst counter
// - read data on bus at edge after the starting edge, if enabled
// - write data taken on second edge after address edge, then written
// - burst counter steps only the two low address bits, wrapping in four
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// write fifo: decouples bus data capture from core update
// ------------------------------------------------------------
module psb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             sys_rst_in,
  // fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW-1:0] rd;
    logic [PW-1:0] wr;
    logic [PW:0]   cnt;
  } psb_fifo_st_t;

  psb_fifo_st_t st;
  psb_fifo_st_t next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign in_ready_out  = (st.cnt != (PW+1)'(DEPTH));
  assign out_valid_out = (st.cnt != '0);
  assign out_data_out  = mem[st.rd];
  assign push = in_valid_in && in_ready_out;
  assign pop  = out_valid_out && out_ready_in;

  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.wr = st.wr + PW'(1);
    end
    if (pop)
    begin
      next_st.rd = st.rd + PW'(1);
    end
    next_st.cnt = st.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // storage has no reset; only pointers and count need a defined start
  always_ff @(posedge clk_sys_in)
  begin
    if (push)
    begin
      mem[st.wr] <= in_data_in;
    end
  end

  chk_fifo_no_overfill: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    st.cnt <= (PW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule : psb_fifo

// ------------------------------------------------------------
// top: sram device
// ------------------------------------------------------------
module psb_sram
#(
  parameter int ADDR_BITS = psb_pkg::ADDR_W
) (
  // clock and reset
  input  wire logic                          clk_sys_in,
  input  wire logic                          sys_rst_in,
  // synchronous control pins
  input  wire logic                          clock_qualify_n_in,
  input  wire logic                          select_first_n_in,
  input  wire logic                          select_second_in,
  input  wire logic                          select_third_n_in,
  input  wire logic                          advance_or_load_in,
  input  wire logic                          write_n_in,
  input  wire logic [psb_pkg::LANES-1:0]     byte_lane_write_n_in,
  input  wire logic [ADDR_BITS-1:0]          addr_in,
  // asynchronous pins
  input  wire logic                          output_enable_n_in,
  input  wire logic                          sleep_request_in,
  input  wire logic                          burst_mode_in,
  // data and parity lanes, split three ways
  input  wire logic [psb_pkg::DATA_W-1:0]    dq_in,
  output logic      [psb_pkg::DATA_W-1:0]    dq_out,
  output logic                               dq_oe_out,
  // status
  output logic                               sleeping_out
);
  import psb_pkg::*;

  localparam int DEPTH_WORDS = 1 << ADDR_BITS;

  typedef struct packed {
    psb_cmd_t                cmd;        // input register
    logic                    zz_meta;
    logic                    zz_sync;
    logic [1:0]              zz_cnt;
    logic                    sleep;
    logic                    mode;
    psb_op_t                 burst_op;
    logic [ADDR_BITS-1:0]    base;
    logic [BURST_W-1:0]      cnt;
    psb_op_t                 s1_op;      // address stage
    logic [ADDR_BITS-1:0]    s1_addr;
    logic [LANES-1:0]        s1_lane;
    logic                    s1_was_desel;
    psb_op_t                 s2_op;      // data stage
    logic [ADDR_BITS-1:0]    s2_addr;
    logic [LANES-1:0]        s2_lane;
    logic                    s2_mask;
    logic [DATA_W-1:0]       dout;
  } psb_st_t;

  psb_st_t st;
  psb_st_t next_st;
  logic [DATA_W-1:0] core [DEPTH_WORDS];
  logic [DATA_W-1:0] rd_word;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  psb_wr_t           fifo_out;
  psb_wr_t           wr_req;
  logic              wr_push;

  function automatic logic [BURST_W-1:0] burst_next(
    input logic               linear,
    input logic [BURST_W-1:0] start,
    input logic [BURST_W-1:0] step
  );
    logic [BURST_W-1:0] r;
    r = linear ? start + step : start ^ step;
    return r;
  endfunction : burst_next

  function automatic logic [DATA_W-1:0] lane_merge(
    input logic [DATA_W-1:0] old_w,
    input logic [DATA_W-1:0] new_w,
    input logic [LANES-1:0]  lane
  );
    logic [DATA_W-1:0] r;
    r = old_w;
    for (int i = 0; i < LANES; i++)
    begin
      if (lane[i])
      begin
        r[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
      end
    end
    return r;
  endfunction : lane_merge

  // ------------------------------------------------------------
  // qualified clock and pipeline
  // ------------------------------------------------------------
  // drain is always ready, so a full fifo never stalls the host in practice
  assign rd_word = core[st.s1_addr];
  assign wr_push = !clock_qualify_n_in && st.s2_op == PSB_WRITE && !st.sleep;
  assign wr_req  = '{addr: st.s2_addr, lane: st.s2_lane, data: dq_in};

  always_comb
  begin
    logic             qual;
    logic [BURST_W-1:0] pos;
    qual = 1'b0;
    pos  = '0;
    next_st = st;
    // two-stage synchroniser; only the second stage is read
    next_st.zz_meta = sleep_request_in;
    next_st.zz_sync = st.zz_meta;
    if (st.zz_sync != st.sleep)
    begin
      next_st.zz_cnt = st.zz_cnt + 2'h1;
      if (st.zz_cnt + 2'h1 >= SLEEP_CYCLES)
      begin
        next_st.sleep  = st.zz_sync;
        next_st.zz_cnt = '0;
      end
    end
    else
    begin
      next_st.zz_cnt = '0;
    end
    // clock-qualify high holds everything else; nothing here deselects
    qual = !clock_qualify_n_in && fifo_in_ready && !st.sleep;
    if (qual)
    begin
      // strap is slow; sampled like any input
      next_st.mode = burst_mode_in;
      next_st.cmd.selected = !select_first_n_in && select_second_in
                             && !select_third_n_in;
      next_st.cmd.adv    = advance_or_load_in;
      next_st.cmd.wr_n   = write_n_in;
      next_st.cmd.lane_n = byte_lane_write_n_in;
      next_st.cmd.addr   = addr_in;
      // address stage from registered command
      next_st.s1_was_desel = (st.s1_op == PSB_IDLE);
      if (st.cmd.adv)
      begin
        // advance ignores selects and strobe; access type held
        pos = st.cnt + 2'h1;
        next_st.cnt   = pos;
        next_st.s1_op = st.burst_op;
        next_st.s1_addr = {st.base[ADDR_BITS-1:BURST_W],
                           burst_next(st.mode == MODE_LINEAR,
                                      st.base[BURST_W-1:0], pos)};
      end
      else if (st.cmd.selected)
      begin
        next_st.base     = st.cmd.addr;
        next_st.cnt      = '0;
        next_st.burst_op = st.cmd.wr_n ? PSB_READ : PSB_WRITE;
        next_st.s1_op    = next_st.burst_op;
        next_st.s1_addr  = st.cmd.addr;
      end
      else
      begin
        next_st.s1_op    = PSB_IDLE;
        next_st.burst_op = PSB_IDLE;
      end
      next_st.s1_lane = ~st.cmd.lane_n;
      // data stage
      next_st.s2_op   = st.s1_op;
      next_st.s2_addr = st.s1_addr;
      next_st.s2_lane = st.s1_lane;
      next_st.s2_mask = st.s1_op != PSB_READ || st.s1_was_desel && st.s1_op == PSB_IDLE;
      if (st.s1_op == PSB_READ)
      begin
        next_st.dout = rd_word;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      st <= '{mode: 1'b1, s2_mask: 1'b1, s1_was_desel: 1'b1,
              burst_op: PSB_IDLE, s1_op: PSB_IDLE, s2_op: PSB_IDLE, default: '0};
    end
    else
    begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // self-timed core write from fifo
  // ------------------------------------------------------------
  psb_fifo #(
    .WIDTH ($bits(psb_wr_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_sys_in    (clk_sys_in),
    .sys_rst_in    (sys_rst_in),
    .in_valid_in   (wr_push),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (wr_req),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (1'b1),
    .out_data_out  (fifo_out)
  );

  // one merge per cycle after the fifo; no host strobe involved
  always_ff @(posedge clk_sys_in)
  begin
    if (fifo_out_valid)
    begin
      core[fifo_out.addr] <= lane_merge(core[fifo_out.addr], fifo_out.data,
                                        fifo_out.lane);
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // read after a just-issued write may see stale data while the fifo drains
  assign dq_out       = st.dout;
  assign dq_oe_out    = !output_enable_n_in && !st.s2_mask && st.s2_op == PSB_READ;
  assign sleeping_out = st.sleep;

  sequence s_qual;
    !clock_qualify_n_in && fifo_in_ready && !st.sleep;
  endsequence
  sequence s_read_start;
    !clock_qualify_n_in && !st.sleep && fifo_in_ready && !st.cmd.adv && st.cmd.selected
      && st.cmd.wr_n;
  endsequence
  sequence s_write_start;
    !clock_qualify_n_in && !st.sleep && fifo_in_ready && !st.cmd.adv && st.cmd.selected
      && !st.cmd.wr_n;
  endsequence

  chk_read_two_stage: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_read_start ##1 s_qual ##1 !output_enable_n_in
    |-> dq_oe_out) else $error("read data not driven");
  chk_hold_freeze: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    clock_qualify_n_in |=> $stable(st.s2_op) && $stable(st.cnt) && $stable(st.dout))
    else $error("state moved while clock masked");
  chk_hold_keeps_select: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    clock_qualify_n_in |=> $stable(st.cmd.selected)) else $error("mask deselected");
  chk_oe_gates_bus: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    output_enable_n_in |-> !dq_oe_out) else $error("bus driven with oe high");
  chk_write_floats: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    st.s2_op != PSB_READ |-> !dq_oe_out) else $error("bus driven in write");
  chk_load_addr: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    !clock_qualify_n_in && fifo_in_ready && !st.sleep && !st.cmd.adv && st.cmd.selected
    |=> st.base == $past(st.cmd.addr) && st.cnt == 2'h0) else $error("address not loaded");
  chk_access_type: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    !clock_qualify_n_in && fifo_in_ready && !st.sleep && !st.cmd.adv && st.cmd.selected
    |=> st.s1_op == ($past(st.cmd.wr_n) ? PSB_READ : PSB_WRITE)) else $error("wrong type");
  chk_burst_step: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    !clock_qualify_n_in && fifo_in_ready && !st.sleep && st.cmd.adv
    |=> st.cnt == $past(st.cnt) + 2'h1 && st.base == $past(st.base)) else $error("no step");
  chk_sleep_entry: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    sleep_request_in [*5] |-> st.sleep) else $error("sleep not entered");
  chk_write_capture: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_write_start ##1 s_qual |=> clock_qualify_n_in || st.sleep
      || wr_push && wr_req.lane == ~$past(st.cmd.lane_n, 2)) else $error("bad capture");
endmodule : psb_sram

`default_nettype wire

// [tb/psb_host.sv]
// host memory controller model that drives the sram bus pins
`timescale 1ns/100ps
`default_nettype none

module psb_host (
  // clock
  input  wire logic                       clk_sys_in,
  // control pins toward the sram
  output var logic                        clock_qualify_n_out,
  output var logic                        select_first_n_out,
  output var logic                        select_second_out,
  output var logic                        select_third_n_out,
  output var logic                        advance_or_load_out,
  output var logic                        write_n_out,
  output var logic [psb_pkg::LANES-1:0]   byte_lane_write_n_out,
  output var logic [psb_pkg::ADDR_W-1:0]  addr_out,
  output var logic                        output_enable_n_out,
  output var logic                        sleep_request_out,
  output var logic                        burst_mode_out,
  // shared data wire
  input  wire logic [psb_pkg::DATA_W-1:0] dq_out_in,
  input  wire logic                       dq_oe_in,
  output logic      [psb_pkg::DATA_W-1:0] dq_bus_out
);
  import psb_pkg::*;

  logic [DATA_W-1:0] drive_val;

  // device drive wins; a released host shows inverted data, never a held copy
  assign dq_bus_out = dq_oe_in ? dq_out_in : drive_val;

  initial
  begin
    clock_qualify_n_out   = 1'b0;
    select_first_n_out    = 1'b1;
    select_second_out     = 1'b0;
    select_third_n_out    = 1'b1;
    advance_or_load_out   = 1'b0;
    write_n_out           = 1'b1;
    byte_lane_write_n_out = 4'hf;
    addr_out              = '0;
    output_enable_n_out   = 1'b0;
    sleep_request_out     = 1'b0;
    burst_mode_out        = MODE_LINEAR;
    drive_val             = '0;
  end

  // one command per falling edge; the three selects move together
  task automatic send(input logic sel, input logic adv, input logic wr_n,
                      input logic [LANES-1:0] lane_n, input logic [ADDR_W-1:0] a);
    @(negedge clk_sys_in);
    select_first_n_out    = ~sel;
    select_second_out     = sel;
    select_third_n_out    = ~sel;
    advance_or_load_out   = adv;
    write_n_out           = wr_n;
    byte_lane_write_n_out = lane_n;
    addr_out              = a;
  endtask : send

  // write data held across the capture edge and the edge before it
  task automatic put_data(input logic [DATA_W-1:0] d);
    drive_val = d;
  endtask : put_data

  task automatic let_go;
    drive_val = ~drive_val;
  endtask : let_go

endmodule : psb_host

`default_nettype wire

// [tb/testbench.sv]
// self-checking testbench for the pipelined burst sram
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import psb_pkg::*;

  logic              clk_sys_in = 1'b0;
  logic              sys_rst_in = 1'b1;
  int                errors     = 0;
  int                compares   = 0;
  logic              cqn, s1n, s2, s3n, adv, wrn, oen, zz, mode, oe, slp;
  logic [LANES-1:0]  lanes;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] dq_bus, dq_drv;

  always #2.5 clk_sys_in = ~clk_sys_in;

  psb_host i_host (.clk_sys_in(clk_sys_in), .clock_qualify_n_out(cqn),
    .select_first_n_out(s1n), .select_second_out(s2), .select_third_n_out(s3n),
    .advance_or_load_out(adv), .write_n_out(wrn), .byte_lane_write_n_out(lanes),
    .addr_out(addr), .output_enable_n_out(oen), .sleep_request_out(zz),
    .burst_mode_out(mode), .dq_out_in(dq_drv), .dq_oe_in(oe), .dq_bus_out(dq_bus));

  psb_sram i_dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .clock_qualify_n_in(cqn), .select_first_n_in(s1n), .select_second_in(s2),
    .select_third_n_in(s3n), .advance_or_load_in(adv), .write_n_in(wrn),
    .byte_lane_write_n_in(lanes), .addr_in(addr), .output_enable_n_in(oen),
    .sleep_request_in(zz), .burst_mode_in(mode), .dq_in(dq_bus), .dq_out(dq_drv),
    .dq_oe_out(oe), .sleeping_out(slp));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [DATA_W-1:0] wd(input logic [ADDR_W-1:0] a);
    return 36'h9a5c3e1f0 ^ {19'h0, a};
  endfunction : wd

  task automatic check(input string what, input logic [DATA_W-1:0] exp,
                       input logic [DATA_W-1:0] got);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic check_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                    input logic [LANES-1:0] lane_n);
    i_host.send(1'b1, 1'b0, 1'b0, lane_n, a);
    i_host.send(1'b0, 1'b0, 1'b1, 4'hf, a);
    @(negedge clk_sys_in);
    i_host.put_data(d);
    @(negedge clk_sys_in);
    check_bit("write phase oe", 1'b0, oe);
    @(negedge clk_sys_in);
    i_host.let_go;
    @(negedge clk_sys_in);
  endtask : wr

  // stall holds clock qualify high after the command edge
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp,
                    input int stall, input logic oe_n);
    i_host.output_enable_n_out = oe_n;
    i_host.send(1'b1, 1'b0, 1'b1, 4'hf, a);
    i_host.send(1'b0, 1'b0, 1'b1, 4'hf, a);
    if (stall != 0)
    begin
      i_host.clock_qualify_n_out = 1'b1;
      repeat (stall) @(negedge clk_sys_in);
      check_bit("stalled oe", 1'b0, oe);
      i_host.clock_qualify_n_out = 1'b0;
    end
    repeat (2) @(negedge clk_sys_in);
    check_bit("read oe", ~oe_n, oe);
    if (!oe_n)
      check("read data", exp, dq_drv);
    @(negedge clk_sys_in);
    check_bit("deselect oe", 1'b0, oe);
    i_host.output_enable_n_out = 1'b0;
  endtask : rd

  task automatic burst(input logic [ADDR_W-1:0] base, input logic md);
    logic [1:0] ofs;
    i_host.burst_mode_out = md;
    for (int i = 0; i < 7; i++)
    begin
      i_host.send(i < 4, (i > 0) && (i < 4), 1'b1, 4'hf, base);
      ofs = md ? (base[1:0] ^ 2'(i - 3)) : (base[1:0] + 2'(i - 3));
      if (i >= 3)
        check("burst data", wd({base[16:2], ofs}), dq_drv);
    end
    $display("test burst mode %b done", md);
  endtask : burst

  task automatic wrap_up;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    logic [DATA_W-1:0] m;
    m = {9'h0, 9'h1ff, 9'h0, 9'h1ff};
    repeat (5) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    sys_rst_in = 1'b0;
    check_bit("reset oe", 1'b0, oe);
    for (int a = 4; a < 8; a++)
      wr(17'(a), wd(17'(a)), 4'h0);
    rd(17'h5, wd(17'h5), 0, 1'b0);
    $display("test single access done");
    rd(17'h6, wd(17'h6), 3, 1'b0);
    rd(17'h7, wd(17'h7), 0, 1'b1);
    $display("test stall and output enable done");
    burst(17'h5, 1'b0);
    burst(17'h7, 1'b1);
    wr(17'h20, 36'h0f0f0f0f0, 4'h0);
    wr(17'h20, 36'hfedcba987, 4'b1010);
    rd(17'h20, (36'hfedcba987 & m) | (36'h0f0f0f0f0 & ~m), 0, 1'b0);
    $display("test byte lanes done");
    i_host.sleep_request_out = 1'b1;
    @(negedge clk_sys_in);
    check_bit("sleep early", 1'b0, slp);
    repeat (6) @(negedge clk_sys_in);
    check_bit("sleep entered", 1'b1, slp);
    i_host.sleep_request_out = 1'b0;
    repeat (6) @(negedge clk_sys_in);
    check_bit("sleep left", 1'b0, slp);
    rd(17'h20, (36'hfedcba987 & m) | (36'h0f0f0f0f0 & ~m), 0, 1'b0);
    $display("test sleep done");
    wrap_up;
  end

  initial
  begin
    repeat (5000) @(posedge clk_sys_in);
    errors++;
    wrap_up;
  end

endmodule : testbench

`default_nettype wire
